// ===== hdl/dcr_addr_step.sv
// address stepper with optional block or repeat restore
`timescale 1ns/10ps
module dcr_addr_step (
  input wire logic [23:0] addr_i,
  input wire dcr_pkg::dcr_step_e mode_i,
  input wire logic word_i,
  input wire logic restore_i,
  input wire logic [8:0] count_i,
  output logic [23:0] addr_o
);

  logic [23:0] delta;
  logic [23:0] span;

  // ----------------------------------------------------------------
  // step and restore
  // ----------------------------------------------------------------
  always_comb begin
    delta = word_i ? 24'h000002 : 24'h000001;
    span = {15'h0000, count_i} << word_i;
    unique case (mode_i)
      dcr_pkg::STEP_UP: begin
        addr_o = restore_i ? addr_i + delta - span : addr_i + delta;
      end
      dcr_pkg::STEP_DOWN: begin
        addr_o = restore_i ? addr_i - delta + span : addr_i - delta;
      end
      // code 3 is not a legal step mode and holds like fixed
      default: begin
        addr_o = addr_i;
      end
    endcase
  end

endmodule // dcr_addr_step

// ===== hdl/dcr_channel_pair.sv
// dma channel pair: repeat, normal and block transfer sequencing
//
// Behaviour
// R01 - repeat mode needs repeat_enable 1 and end_irq_enable 0
// R02 - repeat: one unit per request, memory address steps 1 or 2, io fixed
// R03 - io address upper 8 bits are forced to all ones
// R04 - direction 0: memory is source; direction 1: io is source
// R05 - repeat count is 8 bits; zero means 256 transfers
// R06 - running byte counts down and reloads from the reload byte at zero
// R07 - on reload the memory address returns to its start value
// R08 - software loads reload and running bytes with the same value
// R09 - repeat runs until software clears enable; never an end interrupt
// R10 - re-enabling resumes with current address and count
// R11 - repeat takes serial, timer and external requests; external on channel b
// R12 - normal mode: full_address_enable 1 and block_enable 0
// R13 - full addresses are 24 bits, each steps up, down or stays fixed
// R14 - normal count reaching zero clears enable and may raise end interrupt
// R15 - normal count zero means 65536 transfers
// R16 - normal mode takes external or auto requests; auto needs no request
// R17 - cycle steal frees the bus per transfer; burst holds it to the end
// R18 - block mode: full_address_enable 1 and block_enable 1
// R19 - each request moves one whole block; block side is selectable
// R20 - block size counter bursts to zero, reloads, restores block address
// R21 - block count drops per block; at zero enable clears, interrupt optional
// R22 - block_side_select picks which address is the restored block area
// R23 - a disabled channel ignores requests and does no bus transfers
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module dcr_channel_pair #(
  parameter bit EXT_REQ_ALLOWED = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dcr_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [6:0] int_req_i,
  input wire logic ext_req_n_i,
  output dcr_pkg::dcr_dbus_s dbus_o,
  input wire logic [15:0] dbus_dat_i,
  input wire logic dbus_ack_i,
  output logic end_irq_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dcr_pkg::dcr_ctrl_s ctrl;
  dcr_pkg::dcr_state_e state;
  logic [23:0] short_memory_address;
  logic [15:0] short_io_address;
  logic [7:0] repeat_count_reload;
  logic [7:0] repeat_count_running;
  logic [23:0] full_source_address;
  logic [23:0] full_dest_address;
  logic [15:0] normal_transfer_count;
  logic [15:0] block_count;
  logic ext_s1, ext_s2, ext_s3, ext_level;
  logic ext_fall, ext_ok;
  logic pending, wrap_q;
  logic wr_en, rd_en;
  logic mode_rpt, mode_norm, mode_blk, auto_go;
  logic [7:0] req_vec;
  logic req_evt, start_ok, upd, cont;
  logic rpt_reload, norm_end, blk_wrap, blk_end, hw_end;
  logic [23:0] io_full, src_adr, dst_adr;
  logic [23:0] step_a_in, step_a_out, step_b_out;
  dcr_pkg::dcr_step_e step_a_mode;
  logic [8:0] restore_cnt;
  logic restore_a, restore_b;
  logic [31:0] rd_mux;

  // byte-lane merge shared by every writable register
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  assign mode_rpt = ~ctrl.full_address_enable & ctrl.repeat_enable & ~ctrl.end_irq_enable; // R01
  assign mode_norm = ctrl.full_address_enable & ~ctrl.block_enable; // R12
  assign mode_blk = ctrl.full_address_enable & ctrl.block_enable; // R18
  assign auto_go = mode_norm & ctrl.auto_request; // R16

  // ----------------------------------------------------------------
  // external request pin, three flops, change once two agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
      ext_level <= 1'b1;
    end else begin
      ext_s1 <= ext_req_n_i;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3) begin
        ext_level <= ext_s3;
      end
    end
  end

  assign ext_fall = (ext_s2 == ext_s3) & ~ext_s3 & ext_level;
  // short channels see the pin only on channel b
  assign ext_ok = ext_fall & (EXT_REQ_ALLOWED | ctrl.full_address_enable); // R11

  // ----------------------------------------------------------------
  // request acceptance
  // ----------------------------------------------------------------
  assign req_vec = {ext_ok, int_req_i};
  assign req_evt = ctrl.channel_enable & // R23
                   (((mode_rpt | mode_blk) & req_vec[ctrl.source_select]) | // R11
                    (mode_norm & ~ctrl.auto_request & (ctrl.source_select == dcr_pkg::SRC_EXTERNAL) &
                     ext_ok)); // R16
  assign start_ok = (state == dcr_pkg::ST_IDLE) & ctrl.channel_enable & // R23
                    (mode_rpt | mode_blk | mode_norm) & (pending | auto_go); // R16

  // new request wins over the clear from a start in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending <= 1'b0;
    end else if (req_evt) begin
      pending <= 1'b1;
    end else if (start_ok) begin
      pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // addresses and stepping
  // ----------------------------------------------------------------
  assign io_full = {dcr_pkg::IO_UPPER, short_io_address}; // R03
  assign src_adr = mode_rpt ? (ctrl.direction_select ? io_full : short_memory_address) // R04
                            : full_source_address; // R13
  assign dst_adr = mode_rpt ? (ctrl.direction_select ? short_memory_address : io_full) // R04
                            : full_dest_address; // R13
  assign upd = (state == dcr_pkg::ST_WRITE) & dbus_ack_i;
  assign rpt_reload = repeat_count_running == 8'h01; // R06
  assign norm_end = normal_transfer_count == 16'h0001; // R14
  assign blk_wrap = normal_transfer_count[7:0] == 8'h01; // R20
  assign blk_end = blk_wrap & (block_count == 16'h0001); // R21
  assign hw_end = (mode_norm & norm_end) | (mode_blk & blk_end);

  assign step_a_in = mode_rpt ? short_memory_address : full_source_address;
  assign step_a_mode = mode_rpt ? (ctrl.step_down_select ? dcr_pkg::STEP_DOWN : dcr_pkg::STEP_UP)
                                : ctrl.src_step; // R02
  // a zero count stands for the full 256 in both restore cases
  assign restore_cnt = mode_rpt ? {repeat_count_reload == 8'h00, repeat_count_reload} // R05
                                : {normal_transfer_count[15:8] == 8'h00,
                                   normal_transfer_count[15:8]};
  assign restore_a = mode_rpt ? rpt_reload : (mode_blk & blk_wrap & ctrl.block_side_select); // R07
  assign restore_b = mode_blk & blk_wrap & ~ctrl.block_side_select; // R22

  dcr_addr_step u_step_a (
    .addr_i(step_a_in),
    .mode_i(step_a_mode),
    .word_i(ctrl.size_select),
    .restore_i(restore_a),
    .count_i(restore_cnt),
    .addr_o(step_a_out)
  );

  dcr_addr_step u_step_b (
    .addr_i(full_dest_address),
    .mode_i(ctrl.dst_step),
    .word_i(ctrl.size_select),
    .restore_i(restore_b),
    .count_i(restore_cnt),
    .addr_o(step_b_out)
  );

  // ----------------------------------------------------------------
  // wishbone slave: ack one cycle after strobe, write at the ack edge
  // ----------------------------------------------------------------
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  always_comb begin
    unique case (wb_adr_i)
      dcr_pkg::OFS_CTRL: rd_mux = {14'h0000, ctrl};
      dcr_pkg::OFS_SHORT_MEM: rd_mux = {8'h00, short_memory_address};
      dcr_pkg::OFS_SHORT_IO: rd_mux = {16'h0000, short_io_address};
      dcr_pkg::OFS_REPEAT_CNT: rd_mux = {16'h0000, repeat_count_reload, repeat_count_running};
      dcr_pkg::OFS_FULL_SRC: rd_mux = {8'h00, full_source_address};
      dcr_pkg::OFS_FULL_DST: rd_mux = {8'h00, full_dest_address};
      dcr_pkg::OFS_NORMAL_CNT: rd_mux = {16'h0000, normal_transfer_count};
      dcr_pkg::OFS_BLOCK_CNT: rd_mux = {16'h0000, block_count};
      dcr_pkg::OFS_STATUS: rd_mux = {24'h000000, mode_blk, mode_norm, mode_rpt, wrap_q,
                                     pending, dbus_o.cyc, state};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_en) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register; a software write wins over the hardware clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= dcr_pkg::CTRL_RESET;
    end else begin
      if (upd & hw_end) begin
        ctrl.channel_enable <= 1'b0; // R14 R21
      end
      if (wr_en && wb_adr_i == dcr_pkg::OFS_CTRL) begin
        ctrl <= dcr_pkg::dcr_ctrl_s'(18'(lane_merge({14'h0000, ctrl}, wb_dat_i,
                                                    wb_sel_i)));
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      end_irq_o <= 1'b0;
    end else begin
      // repeat mode never reaches hw_end
      end_irq_o <= upd & hw_end & ctrl.end_irq_enable; // R09 R14 R21
    end
  end

  // ----------------------------------------------------------------
  // addresses; held across a disable so a restart resumes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      short_memory_address <= dcr_pkg::ADDR_RESET;
      short_io_address <= dcr_pkg::IO_RESET;
      full_source_address <= dcr_pkg::ADDR_RESET;
      full_dest_address <= dcr_pkg::ADDR_RESET;
    end else begin
      if (upd & mode_rpt) begin
        short_memory_address <= step_a_out; // R02 R07 R10
      end
      if (upd & (mode_norm | mode_blk)) begin
        full_source_address <= step_a_out; // R13 R20
        full_dest_address <= step_b_out; // R13 R22
      end
      if (wr_en && wb_adr_i == dcr_pkg::OFS_SHORT_MEM) begin
        short_memory_address <= 24'(lane_merge({8'h00, short_memory_address}, wb_dat_i,
                                               wb_sel_i));
      end
      if (wr_en && wb_adr_i == dcr_pkg::OFS_SHORT_IO) begin
        short_io_address <= 16'(lane_merge({16'h0000, short_io_address}, wb_dat_i, wb_sel_i));
      end
      if (wr_en && wb_adr_i == dcr_pkg::OFS_FULL_SRC) begin
        full_source_address <= 24'(lane_merge({8'h00, full_source_address}, wb_dat_i,
                                              wb_sel_i));
      end
      if (wr_en && wb_adr_i == dcr_pkg::OFS_FULL_DST) begin
        full_dest_address <= 24'(lane_merge({8'h00, full_dest_address}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      repeat_count_reload <= dcr_pkg::COUNT8_RESET;
      repeat_count_running <= dcr_pkg::COUNT8_RESET;
      normal_transfer_count <= dcr_pkg::COUNT16_RESET;
      block_count <= dcr_pkg::COUNT16_RESET;
      wrap_q <= 1'b0;
    end else begin
      if (upd & mode_rpt) begin
        // zero wraps through ff, giving 256 transfers
        repeat_count_running <= rpt_reload ? repeat_count_reload // R06
                                           : repeat_count_running - 8'h01; // R05
      end
      if (upd & mode_norm) begin
        normal_transfer_count <= normal_transfer_count - 16'h0001; // R14 R15
      end
      if (upd & mode_blk) begin
        normal_transfer_count[7:0] <= blk_wrap ? normal_transfer_count[15:8] // R20
                                               : normal_transfer_count[7:0] - 8'h01;
        if (blk_wrap) begin
          block_count <= block_count - 16'h0001; // R21
        end
      end
      if (upd) begin
        wrap_q <= blk_wrap;
      end
      if (wr_en && wb_adr_i == dcr_pkg::OFS_REPEAT_CNT) begin
        {repeat_count_reload, repeat_count_running} <= 16'(lane_merge(
          {16'h0000, repeat_count_reload, repeat_count_running}, wb_dat_i, wb_sel_i));
      end
      if (wr_en && wb_adr_i == dcr_pkg::OFS_NORMAL_CNT) begin
        normal_transfer_count <= 16'(lane_merge({16'h0000, normal_transfer_count}, wb_dat_i,
                                                wb_sel_i));
      end
      if (wr_en && wb_adr_i == dcr_pkg::OFS_BLOCK_CNT) begin
        block_count <= 16'(lane_merge({16'h0000, block_count}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer: read source, write destination, update
  // ----------------------------------------------------------------
  // a block keeps going to its end; burst auto-request to the count end
  assign cont = ctrl.channel_enable & ((mode_blk & ~wrap_q) | // R19 R20
                                       (auto_go & ctrl.burst_select)); // R17

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= dcr_pkg::ST_IDLE;
    end else begin
      unique case (state)
        dcr_pkg::ST_IDLE: begin
          if (start_ok) begin
            state <= dcr_pkg::ST_READ;
          end
        end
        dcr_pkg::ST_READ: begin
          if (dbus_ack_i) begin
            state <= dcr_pkg::ST_WRITE;
          end
        end
        dcr_pkg::ST_WRITE: begin
          if (dbus_ack_i) begin
            state <= dcr_pkg::ST_UPDATE;
          end
        end
        dcr_pkg::ST_UPDATE: begin
          state <= cont ? dcr_pkg::ST_READ : dcr_pkg::ST_IDLE; // R09 R17
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbus_o <= dcr_pkg::DBUS_RESET;
    end else begin
      if (start_ok | ((state == dcr_pkg::ST_UPDATE) & cont)) begin
        dbus_o.cyc <= 1'b1;
        dbus_o.we <= 1'b0;
        dbus_o.word <= ctrl.size_select;
        dbus_o.adr <= src_adr;
        dbus_o.lock <= mode_blk | (auto_go & ctrl.burst_select); // R17 R20
      end else if ((state == dcr_pkg::ST_READ) & dbus_ack_i) begin
        // bus stays ours between the read and the write
        dbus_o.we <= 1'b1;
        dbus_o.adr <= dst_adr;
        dbus_o.dat <= dbus_dat_i;
      end else if (upd) begin
        dbus_o.cyc <= 1'b0;
        dbus_o.we <= 1'b0;
      end else if ((state == dcr_pkg::ST_UPDATE) & ~cont) begin
        dbus_o.lock <= 1'b0; // R17
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_rpt_no_irq;
    upd && mode_rpt |=> !end_irq_o;
  endproperty
  a_rpt_no_irq: assert property (p_rpt_no_irq) else $error("end interrupt in repeat mode"); // R09

  property p_io_upper;
    dbus_o.cyc && dbus_o.we && mode_rpt && !ctrl.direction_select |->
      dbus_o.adr[23:16] == 8'hff;
  endproperty
  a_io_upper: assert property (p_io_upper) else $error("io address upper byte not ff"); // R03

  property p_dir_src;
    $rose(dbus_o.cyc) && mode_rpt && !ctrl.direction_select |->
      dbus_o.adr == short_memory_address && !dbus_o.we;
  endproperty
  a_dir_src: assert property (p_dir_src) else $error("repeat read not from memory"); // R04

  property p_rpt_step;
    upd && mode_rpt && !rpt_reload && !ctrl.size_select && !ctrl.step_down_select && !wr_en
      |=> short_memory_address == $past(short_memory_address) + 24'h000001;
  endproperty
  a_rpt_step: assert property (p_rpt_step) else $error("repeat address did not step"); // R02

  property p_rpt_reload;
    upd && mode_rpt && rpt_reload && !wr_en |=> repeat_count_running == $past(repeat_count_reload);
  endproperty
  a_rpt_reload: assert property (p_rpt_reload) else $error("repeat count not reloaded"); // R06

  property p_norm_end;
    upd && mode_norm && norm_end && !wr_en |=>
      !ctrl.channel_enable && (end_irq_o == $past(ctrl.end_irq_enable));
  endproperty
  a_norm_end: assert property (p_norm_end) else $error("normal end not handled"); // R14

  property p_idle_disabled;
    state == dcr_pkg::ST_IDLE && !ctrl.channel_enable && !(wr_en && wb_adr_i == dcr_pkg::OFS_CTRL)
      |=> !dbus_o.cyc [*2];
  endproperty
  a_idle_disabled: assert property (p_idle_disabled) else $error("bus used while disabled"); // R23

  property p_steal_release;
    state == dcr_pkg::ST_UPDATE && auto_go && !ctrl.burst_select |=> !dbus_o.cyc && !dbus_o.lock;
  endproperty
  a_steal_release: assert property (p_steal_release) else $error("bus kept in cycle steal"); // R17

  property p_block_lock;
    state == dcr_pkg::ST_UPDATE && mode_blk && !wrap_q && ctrl.channel_enable |=>
      dbus_o.cyc && dbus_o.lock && state == dcr_pkg::ST_READ;
  endproperty
  a_block_lock: assert property (p_block_lock) else $error("block burst broken"); // R20

  property p_block_cnt;
    upd && mode_blk && blk_wrap && !wr_en |=> block_count == $past(block_count) - 16'h0001;
  endproperty
  a_block_cnt: assert property (p_block_cnt) else $error("block count not decremented"); // R21

endmodule // dcr_channel_pair

// ===== hdl/dcr_pkg.sv
// shared constants, register map and carriers for the dma channel pair
package dcr_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets on the wishbone side)
  // ----------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SHORT_MEM = 8'h04;
  localparam logic [7:0] OFS_SHORT_IO = 8'h08;
  localparam logic [7:0] OFS_REPEAT_CNT = 8'h0c;
  localparam logic [7:0] OFS_FULL_SRC = 8'h10;
  localparam logic [7:0] OFS_FULL_DST = 8'h14;
  localparam logic [7:0] OFS_NORMAL_CNT = 8'h18;
  localparam logic [7:0] OFS_BLOCK_CNT = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ----------------------------------------------------------------
  // fixed values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IO_UPPER = 8'hff;
  localparam logic [2:0] SRC_EXTERNAL = 3'h7;
  localparam int CTRL_W = 18;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  localparam logic [15:0] IO_RESET = 16'h0000;
  localparam logic [7:0] COUNT8_RESET = 8'h00;
  localparam logic [15:0] COUNT16_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STEP_FIXED = 2'h0,
    STEP_UP = 2'h1,
    STEP_DOWN = 2'h2
  } dcr_step_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11,
    ST_UPDATE = 2'b10
  } dcr_state_e;

  // bit 0 is channel_enable, bits 17:15 the request source
  typedef struct packed {
    logic [2:0] source_select;
    logic burst_select;
    logic auto_request;
    dcr_step_e dst_step;
    dcr_step_e src_step;
    logic block_side_select;
    logic block_enable;
    logic full_address_enable;
    logic step_down_select;
    logic size_select;
    logic direction_select;
    logic end_irq_enable;
    logic repeat_enable;
    logic channel_enable;
  } dcr_ctrl_s;

  localparam dcr_ctrl_s CTRL_RESET = '0;

  // system bus request driven by the channel
  typedef struct packed {
    logic cyc;
    logic lock;
    logic we;
    logic word;
    logic [23:0] adr;
    logic [15:0] dat;
  } dcr_dbus_s;

  localparam dcr_dbus_s DBUS_RESET = '0;

endpackage

// ===== testbench/dcr_bus_model.sv
// system bus slave model answering the channel's reads and writes
`timescale 1ns/10ps
module dcr_bus_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dcr_pkg::dcr_dbus_s bus_i,
  input wire logic [3:0] wait_i,
  output logic [15:0] dat_o,
  output logic ack_o
);
  logic [3:0] cnt;
  // idle bus shows the inverse, so stale data never matches
  assign dat_o = ack_o ? bus_i.adr[15:0] : ~bus_i.adr[15:0];
  always_ff @(posedge clk_i) begin
    if (rst_i || !bus_i.cyc || ack_o) begin
      cnt <= 4'h0;
      ack_o <= 1'b0;
    end else if (cnt >= wait_i) begin
      ack_o <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // dcr_bus_model

// ===== testbench/tb_dcr_channel_pair.sv
// self-checking bench for the dma channel pair
`timescale 1ns/10ps
module tb_dcr_channel_pair;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, dack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, wdo;
  logic [6:0] req = 7'h00;
  logic [3:0] wt = 4'h0;
  logic ext_n = 1'b1, lk = 1'b0;
  logic [15:0] ddat;
  dcr_pkg::dcr_dbus_s dbus;
  logic [23:0] ra[$], wa[$];
  int failures = 0, n_compared = 0, n_irq = 0;
  always #25 clk_i = ~clk_i;
  dcr_channel_pair u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(wdo),
    .wb_ack_o(ack), .int_req_i(req), .ext_req_n_i(ext_n), .dbus_o(dbus),
    .dbus_dat_i(ddat), .dbus_ack_i(dack), .end_irq_o(irq));
  dcr_bus_model u_bus (.clk_i(clk_i), .rst_i(rst_i), .bus_i(dbus), .wait_i(wt),
    .dat_o(ddat), .ack_o(dack));
  always @(posedge clk_i) begin
    if (dbus.cyc && dack && !dbus.we) ra.push_back(dbus.adr);
    if (dbus.cyc && dack && dbus.we) wa.push_back(dbus.adr);
    if (dbus.cyc && dack && dbus.we) chk(dbus.dat, ra[$][15:0]);
    if (dbus.cyc && dack) chk({dbus.word, dbus.lock}, {1'b0, lk});
    if (irq === 1'b1) n_irq++;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    rd = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20) chk(32'h0, 32'h1);
    if (i == 20) wrap_up();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // wait until n reads are logged and the bus is free again
  task automatic reads(input int n);
    int i;
    for (i = 0; i < 300 && (ra.size() < n || dbus.cyc); i++) @(posedge clk_i);
    if (i == 300) chk(32'h0, 32'h1);
    if (i == 300) wrap_up();
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pl;
    @(posedge clk_i);
    req <= 7'h01;
    @(posedge clk_i);
    req <= 7'h00;
  endtask
  task automatic pe;
    @(posedge clk_i);
    ext_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    ext_n <= 1'b1;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(dcr_pkg::OFS_CTRL, 32'h0);
    wb(1'b1, dcr_pkg::OFS_FULL_SRC, 32'h100);
    rchk(dcr_pkg::OFS_FULL_SRC, 32'h100);
    rchk(8'h24, 32'h0);
    // slow bus, auto request, cycle steal, three bytes
    wt <= 4'h3;
    wb(1'b1, dcr_pkg::OFS_FULL_DST, 32'h200);
    wb(1'b1, dcr_pkg::OFS_NORMAL_CNT, 32'h3);
    wb(1'b1, dcr_pkg::OFS_CTRL, 32'h2245);
    reads(3);
    for (int k = 0; k < 3; k++) begin
      chk(ra[k], 32'h100 + k);
      chk(wa[k], 32'h200);
    end
    chk(n_irq, 1);
    rchk(dcr_pkg::OFS_CTRL, 32'h2244);
    rchk(dcr_pkg::OFS_NORMAL_CNT, 32'h0);
    rchk(dcr_pkg::OFS_FULL_SRC, 32'h103);
    // prompt bus, repeat mode with reload of two
    wt <= 4'h0;
    ra.delete();
    wa.delete();
    wb(1'b1, dcr_pkg::OFS_SHORT_MEM, 32'h1000);
    wb(1'b1, dcr_pkg::OFS_SHORT_IO, 32'h10);
    wb(1'b1, dcr_pkg::OFS_REPEAT_CNT, 32'h0202);
    wb(1'b1, dcr_pkg::OFS_CTRL, 32'h3);
    for (int k = 0; k < 3; k++) begin
      pl();
      reads(k + 1);
    end
    wb(1'b1, dcr_pkg::OFS_CTRL, 32'h2);
    pl();
    repeat (20) @(posedge clk_i);
    chk(ra.size(), 3);
    wb(1'b1, dcr_pkg::OFS_CTRL, 32'h3);
    pl();
    reads(4);
    for (int k = 0; k < 4; k++) begin
      chk(ra[k], 32'h1000 + k % 2);
      chk(wa[k], 32'hff0010);
    end
    rchk(dcr_pkg::OFS_REPEAT_CNT, 32'h0202);
    chk(n_irq, 1);
    // block mode from the pin: two blocks of two bytes, destination is the block area
    ra.delete();
    wa.delete();
    lk <= 1'b1;
    wb(1'b1, dcr_pkg::OFS_FULL_SRC, 32'h300);
    wb(1'b1, dcr_pkg::OFS_FULL_DST, 32'h400);
    wb(1'b1, dcr_pkg::OFS_NORMAL_CNT, 32'h0202);
    wb(1'b1, dcr_pkg::OFS_BLOCK_CNT, 32'h2);
    wb(1'b1, dcr_pkg::OFS_CTRL, 32'h38ac5);
    pe();
    reads(2);
    pe();
    reads(4);
    for (int k = 0; k < 4; k++) begin
      chk(ra[k], 32'h300 + k);
      chk(wa[k], 32'h400 + k % 2);
    end
    chk(ra.size(), 4);
    chk(n_irq, 2);
    rchk(dcr_pkg::OFS_CTRL, 32'h38ac4);
    rchk(dcr_pkg::OFS_NORMAL_CNT, 32'h0202);
    rchk(dcr_pkg::OFS_BLOCK_CNT, 32'h0);
    wrap_up();
  end
endmodule // tb_dcr_channel_pair
